// *** rtl/otp_cmd_device.sv ***
// Display driver end: store, status and CRC command interpreter
// Function
// - Status read returns one byte, reset 0x22
// - Bit 5 drive rail not ready, reset 1
// - Bit 4 supply input low, reset 0
// - Bit 2 busy, bit 3 zero
// - Bits 1..0 fixed chip code
// - 0x14 and 0x15 validate rail, supply flags
// - Waveform program writes store from loaded content
// - Waveform load copies store into working table
// - Host keeps clock gate on for store ops
// - Busy high during program, load, CRC
// - Table write takes 70 parameter bytes
// - CRC over stored waveform setting, busy held
// - CRC read returns upper byte first
// - Selection program stores selection and user ID
// - Selection write seven bytes, first bit7 only
// - Sixth, seventh bytes module ID and version
// - User ID write takes ten bytes
`timescale 1ns/1ps
`default_nettype none
module otp_cmd_device
  import otp_cmd_pkg::*;
#(
  parameter logic [1:0] CHIP_ID    = 2'b10,  // Arbitrary value
  parameter logic [7:0] COM_LEVEL  = 8'h00
) (
  // Clock and reset
  input  wire logic I_CLK_SYS,
  input  wire logic I_SYS_RST,
  // Link
  otp_link_if.dev   link,
  // Analog sense
  input  wire logic I_DRIVE_RAIL_READY,
  input  wire logic I_SUPPLY_LOW,
  // Status out
  output logic      O_BUSY,
  output logic      O_SPARE_COM_SEL
);
  typedef enum logic {IDLE, OP} state_e;
  typedef struct packed {
    state_e                        state;
    logic [7:0]                    cmd;
    logic [6:0]                    idx;
    logic [6:0]                    cnt;
    logic                          rail_valid;
    logic                          supply_valid;
    logic [15:0]                   crc;
    logic [TABLE_BYTES-1:0][7:0]   table_reg;
    logic [TABLE_BYTES-1:0][7:0]   store_table;
    logic [SEL_BYTES-1:0][7:0]     sel;
    logic [SEL_BYTES-1:0][7:0]     store_sel;
    logic [USER_ID_BYTES-1:0][7:0] uid;
    logic [USER_ID_BYTES-1:0][7:0] store_uid;
    logic                          rd_valid;
    logic                          rd_dc;
    logic [7:0]                    rdata;
    logic                          busy;
  } dev_s;

  dev_s r;
  dev_s next_r;
  logic cmd_take;
  logic par_take;

  // Command and parameter bytes told apart by the data select
  assign cmd_take = link.wr && !link.dc;
  assign par_take = link.wr && link.dc;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) begin
      v = v[15] ? ((v << 1) ^ CRC_POLY) : (v << 1);
    end
    return v;
  endfunction

  function automatic logic [7:0] read_byte(input dev_s s, input logic a, input logic u);
    logic [7:0] b;
    b = 8'h00;
    case (s.cmd)
      CMD_STATUS_READ: begin
        // Flags show their reset values until their init commands arrive
        b[ST_DRIVE_RAIL] = s.rail_valid ? ~a : 1'b1;
        b[ST_SUPPLY]     = s.supply_valid & u;
        b[ST_BUSY]       = s.busy;
        b[1:0]           = CHIP_ID;
      end
      CMD_CRC_READ: begin
        if (s.idx == 7'd0) b = s.crc[15:8];
        else if (s.idx == 7'd1) b = s.crc[7:0];
      end
      CMD_USER_ID_READ: begin
        if (s.idx < 7'(USER_ID_BYTES)) b = s.store_uid[s.idx];
      end
      CMD_OPTION_READ: begin
        if (s.idx == 7'd0) b = s.store_sel[0];
        else if (s.idx == 7'd1) b = COM_LEVEL;
        else if (s.idx < 7'(OPTION_BYTES)) b = s.store_sel[s.idx - 7'd1];
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Index saturates so stray extra bytes never wrap back onto index 0
  function automatic logic [6:0] idx_step(input logic [6:0] i);
    logic [6:0] n;
    n = i + 7'd1;
    if (i == 7'h7F) n = i;
    return n;
  endfunction

  // Selection program walks the user ID list, table ops the whole table
  function automatic logic op_done(input logic [7:0] c, input logic [6:0] n);
    logic d;
    case (c)
      CMD_SEL_PROGRAM: d = (n == 7'(USER_ID_BYTES - 1));
      default:         d = (n == 7'(TABLE_BYTES - 1));
    endcase
    return d;
  endfunction

  always_comb begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.rd_dc = 1'b0;
    next_r.rdata = 8'h00;
    // Reads answered even while busy; they then return 0x00, as the current command is the store command
    if (link.rd) begin
      next_r.rd_valid = 1'b1;
      next_r.rd_dc = 1'b1;
      next_r.rdata = read_byte(r, I_DRIVE_RAIL_READY, I_SUPPLY_LOW);
      next_r.idx = idx_step(r.idx);
    end
    case (r.state)
      IDLE: begin
        if (cmd_take) begin
          next_r.cmd = link.wdata;
          next_r.idx = 7'd0;
          next_r.cnt = 7'd0;
          case (link.wdata)
            CMD_DRIVE_RAIL_INIT: next_r.rail_valid = 1'b1;
            CMD_SUPPLY_INIT: next_r.supply_valid = 1'b1;
            CMD_WS_PROGRAM, CMD_WS_LOAD, CMD_SEL_PROGRAM: next_r.state = OP;
            CMD_CRC_CALC: begin
              next_r.state = OP;
              next_r.crc = CRC_SEED;
            end
            default: next_r.state = IDLE;
          endcase
        end else if (par_take) begin
          next_r.idx = idx_step(r.idx);
          case (r.cmd)
            CMD_TABLE_WRITE: begin
              if (r.idx < 7'(TABLE_BYTES)) next_r.table_reg[r.idx] = link.wdata;
            end
            CMD_SEL_WRITE: begin
              if (r.idx == 7'd0) next_r.sel[0] = {link.wdata[7], 7'h00};
              else if (r.idx < 7'(SEL_BYTES)) next_r.sel[r.idx] = link.wdata;
            end
            CMD_USER_ID_WRITE: begin
              if (r.idx < 7'(USER_ID_BYTES)) next_r.uid[r.idx] = link.wdata;
            end
            default: next_r.idx = idx_step(r.idx);
          endcase
        end
      end
      OP: begin
        // Link writes are dropped until the operation ends
        next_r.cnt = r.cnt + 7'd1;
        case (r.cmd)
          CMD_WS_PROGRAM: next_r.store_table[r.cnt] = r.table_reg[r.cnt];
          CMD_WS_LOAD: next_r.table_reg[r.cnt] = r.store_table[r.cnt];
          CMD_CRC_CALC: next_r.crc = crc_byte(r.crc, r.store_table[r.cnt]);
          default: begin
            if (r.cnt < 7'(SEL_BYTES)) next_r.store_sel[r.cnt] = r.sel[r.cnt];
            next_r.store_uid[r.cnt] = r.uid[r.cnt];
          end
        endcase
        if (op_done(r.cmd, r.cnt)) begin
          next_r.state = IDLE;
        end
      end
      default: next_r.state = IDLE;
    endcase
    next_r.busy = (next_r.state == OP);
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      r <= '0;
      r.state <= IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign link.rd_valid   = r.rd_valid;
  assign link.rd_dc      = r.rd_dc;
  assign link.rdata      = r.rdata;
  assign link.busy       = r.busy;
  assign O_BUSY          = r.busy;
  assign O_SPARE_COM_SEL = r.store_sel[0][7];
endmodule
`default_nettype wire

// *** rtl/otp_cmd_pkg.sv ***
// Shared constants for the store, status and CRC command link
package otp_cmd_pkg;
  // Command codes
  localparam logic [7:0] CMD_DRIVE_RAIL_INIT = 8'h14;
  localparam logic [7:0] CMD_SUPPLY_INIT     = 8'h15;
  localparam logic [7:0] CMD_RAM_WRITE_BW    = 8'h24;
  localparam logic [7:0] CMD_RAM_WRITE_RED   = 8'h26;
  localparam logic [7:0] CMD_OPTION_READ     = 8'h2D;
  localparam logic [7:0] CMD_USER_ID_READ    = 8'h2E;
  localparam logic [7:0] CMD_STATUS_READ     = 8'h2F;
  localparam logic [7:0] CMD_WS_PROGRAM      = 8'h30;
  localparam logic [7:0] CMD_WS_LOAD         = 8'h31;
  localparam logic [7:0] CMD_TABLE_WRITE     = 8'h32;
  localparam logic [7:0] CMD_CRC_CALC        = 8'h34;
  localparam logic [7:0] CMD_CRC_READ        = 8'h35;
  localparam logic [7:0] CMD_SEL_PROGRAM     = 8'h36;
  localparam logic [7:0] CMD_SEL_WRITE       = 8'h37;
  localparam logic [7:0] CMD_USER_ID_WRITE   = 8'h38;
  // Parameter byte counts
  localparam int TABLE_BYTES  = 70;
  localparam int SEL_BYTES    = 7;
  localparam int USER_ID_BYTES = 10;
  localparam int OPTION_BYTES = 8;
  // Status byte field positions
  localparam int ST_DRIVE_RAIL = 5;
  localparam int ST_SUPPLY     = 4;
  localparam int ST_BUSY       = 2;
  // CRC-16 seed and polynomial
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // Host register offsets
  localparam logic [4:0] HREG_TX   = 5'h00;
  localparam logic [4:0] HREG_READ = 5'h04;
  localparam logic [4:0] HREG_RX   = 5'h08;
  localparam logic [4:0] HREG_CFG  = 5'h0C;
  localparam logic [4:0] HREG_STAT = 5'h10;
  // Host field positions
  localparam int TX_DC       = 8;
  localparam int RX_VALID    = 8;
  localparam int CFG_CLK_ON  = 0;
  localparam int HS_BUSY     = 0;
  localparam int HS_RAIL_INI = 1;
  localparam int HS_SUP_INI  = 2;
  localparam int HS_RAM_OK   = 3;
  localparam int HS_REFUSED  = 4;
  localparam int HS_SHORT    = 5;
endpackage

// *** rtl/otp_link_if.sv ***
// Byte link between host controller and display driver command port
`timescale 1ns/1ps
`default_nettype none
interface otp_link_if;
  logic       wr;
  logic       dc;
  logic [7:0] wdata;
  logic       rd;
  logic       rd_valid;
  logic       rd_dc;
  logic [7:0] rdata;
  logic       busy;
  modport dev  (input wr, dc, wdata, rd, output rd_valid, rd_dc, rdata, busy);
  modport host (output wr, dc, wdata, rd, input rd_valid, rd_dc, rdata, busy);
endinterface
`default_nettype wire

// *** rtl/otp_cmd_host.sv ***
// Host controller end: register port to command byte link
`timescale 1ns/1ps
`default_nettype none
module otp_cmd_host
  import otp_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_SYS_RST,
  // Register port
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // Link
  otp_link_if.host         link
);
  typedef struct packed {
    logic        wr;
    logic        dc;
    logic [7:0]  wdata;
    logic        rd;
    logic [8:0]  rx;
    logic        clk_gate_on;
    logic        rail_init;
    logic        supply_init;
    logic        ram_ok;
    logic        refused;
    logic        short_params;
    logic [6:0]  remain;
    logic [31:0] rdata;
  } host_s;

  host_s r;
  host_s next_r;
  logic [7:0] tx_byte;
  logic       tx_dc;
  logic       refuse;

  always_comb begin
    tx_byte = I_WDATA[7:0];
    tx_dc = I_WDATA[TX_DC];
    refuse = link.busy;
    if (!tx_dc) begin
      case (tx_byte)
        CMD_WS_PROGRAM: refuse = refuse | ~r.clk_gate_on | ~r.ram_ok;
        CMD_WS_LOAD, CMD_SEL_PROGRAM: refuse = refuse | ~r.clk_gate_on;
        CMD_STATUS_READ: refuse = refuse | ~r.rail_init | ~r.supply_init;
        default: refuse = refuse;
      endcase
    end
    next_r = r;
    next_r.wr = 1'b0;
    next_r.rd = 1'b0;
    next_r.rdata = 32'h0000_0000;
    if (I_WR && I_ADDR == HREG_TX) begin
      if (refuse) begin
        next_r.refused = 1'b1;
      end else begin
        next_r.wr = 1'b1;
        next_r.dc = tx_dc;
        next_r.wdata = tx_byte;
        if (tx_dc) begin
          if (r.remain != 7'd0) next_r.remain = r.remain - 7'd1;
        end else begin
          if (r.remain != 7'd0) next_r.short_params = 1'b1;
          case (tx_byte)
            CMD_TABLE_WRITE: next_r.remain = 7'(TABLE_BYTES);
            CMD_SEL_WRITE: next_r.remain = 7'(SEL_BYTES);
            CMD_USER_ID_WRITE: next_r.remain = 7'(USER_ID_BYTES);
            default: next_r.remain = 7'd0;
          endcase
          if (tx_byte == CMD_DRIVE_RAIL_INIT) next_r.rail_init = 1'b1;
          if (tx_byte == CMD_SUPPLY_INIT) next_r.supply_init = 1'b1;
          if (tx_byte == CMD_RAM_WRITE_BW || tx_byte == CMD_RAM_WRITE_RED) next_r.ram_ok = 1'b1;
        end
      end
    end
    if (I_WR && I_ADDR == HREG_READ) next_r.rd = 1'b1;
    if (I_WR && I_ADDR == HREG_CFG) next_r.clk_gate_on = I_WDATA[CFG_CLK_ON];
    // Refused flag: a new refusal in the clearing cycle keeps it set; the short flag has no such guard
    if (I_WR && I_ADDR == HREG_STAT) begin
      if (I_WDATA[HS_REFUSED] && !(I_WR && I_ADDR == HREG_TX && refuse)) next_r.refused = 1'b0;
      if (I_WDATA[HS_SHORT]) next_r.short_params = 1'b0;
    end
    if (link.rd_valid && link.rd_dc) next_r.rx = {1'b1, link.rdata};
    if (I_RD) begin
      case (I_ADDR)
        HREG_RX: next_r.rdata = {23'h00_0000, r.rx};
        HREG_CFG: next_r.rdata = {31'h0000_0000, r.clk_gate_on};
        HREG_STAT: next_r.rdata = {26'h000_0000, r.short_params, r.refused, r.ram_ok,
                                    r.supply_init, r.rail_init, link.busy};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.wr    = r.wr;
  assign link.dc    = r.dc;
  assign link.wdata = r.wdata;
  assign link.rd    = r.rd;
  assign O_RDATA    = r.rdata;
endmodule
`default_nettype wire

// *** tb/otp_link_monitor.sv ***
// Link checker for the store, status and CRC command byte link
`timescale 1ns/1ps
`default_nettype none
module otp_link_monitor
  import otp_cmd_pkg::*;
(
  input wire logic       I_CLK_SYS,
  input wire logic       I_SYS_RST,
  input wire logic       wr,
  input wire logic       dc,
  input wire logic [7:0] wdata,
  input wire logic       rd,
  input wire logic       rd_valid,
  input wire logic       rd_dc,
  input wire logic [7:0] rdata,
  input wire logic       busy
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  logic [7:0] last_cmd;
  logic [7:0] run;
  logic       cmd_ok;
  // Writes during busy are dropped, so they never count as commands
  assign cmd_ok = wr && !dc && !busy;
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      last_cmd <= 8'h00;
      run      <= 8'h00;
    end else begin
      run      <= busy ? run + 8'h01 : 8'h00;
      last_cmd <= cmd_ok ? wdata : last_cmd;
    end
  end
  sequence long_op_s;
    cmd_ok && (wdata == CMD_CRC_CALC || wdata == CMD_WS_PROGRAM || wdata == CMD_WS_LOAD);
  endsequence
  sequence busy_hold_s;
    busy [*8];
  endsequence
  read_answer_a: assert property (rd |=> rd_valid && rd_dc)
    else $error("read not answered with data select high");
  read_cause_a: assert property (rd_valid |-> $past(rd))
    else $error("read data without a read");
  read_quiet_a: assert property (!rd_valid |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  long_busy_a: assert property (long_op_s |=> busy_hold_s)
    else $error("busy not raised for long operation");
  sel_busy_a: assert property (cmd_ok && wdata == CMD_SEL_PROGRAM |=> busy_hold_s)
    else $error("busy not raised for selection program");
  busy_length_a: assert property ($fell(busy) |-> run == 8'h46 || run == 8'h0A)
    else $error("busy length wrong");
  busy_cause_a: assert property ($rose(busy) |-> $past(cmd_ok) && $past(wdata[7:4]) == 4'h3)
    else $error("busy without a store command");
  status_fixed_a: assert property (rd_valid && last_cmd == CMD_STATUS_READ |-> rdata[7:6] == 2'h0 && !rdata[3])
    else $error("status fixed bits wrong");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Bench joining host controller and driver ends over the byte link
`timescale 1ns/1ps
`default_nettype none
module testbench
  import otp_cmd_pkg::*;
;
  localparam logic [1:0] CHIP  = 2'h2;  // Arbitrary value
  localparam logic [7:0] LEVEL = 8'h5C;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        rail_ready = 1'b0;
  logic        supply_low = 1'b0;
  logic        busy_o;
  logic        spare_sel;
  logic [31:0] rv;
  logic [15:0] crc;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  otp_link_if link();
  otp_cmd_host otp_cmd_host_i (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .link(link.host));
  otp_cmd_device #(.CHIP_ID(CHIP), .COM_LEVEL(LEVEL)) otp_cmd_device_i (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .link(link.dev), .I_DRIVE_RAIL_READY(rail_ready), .I_SUPPLY_LOW(supply_low), .O_BUSY(busy_o),
    .O_SPARE_COM_SEL(spare_sel));
  otp_link_monitor otp_link_monitor_i (.I_CLK_SYS(clk), .I_SYS_RST(rst), .wr(link.wr), .dc(link.dc),
    .wdata(link.wdata), .rd(link.rd), .rd_valid(link.rd_valid), .rd_dc(link.rd_dc), .rdata(link.rdata),
    .busy(link.busy));
  always #4 clk = ~clk;
  function automatic logic [7:0] tbyte(input int i);
    return 8'(i * 37 + 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic send(input logic [7:0] b, input logic d);
    wreg(HREG_TX, {23'h0, d, b});
  endtask
  task automatic getb(input logic [7:0] exp);
    wreg(HREG_READ, 32'h0000_0000);
    repeat (3) @(posedge clk);
    rreg(HREG_RX);
    chk(rv[8:0], {1'b1, exp});
  endtask
  task automatic idle();
    repeat (3) @(posedge clk);
    for (int n = 0; n < 100; n++) begin
      rreg(HREG_STAT);
      if (rv[HS_BUSY] === 1'b0) break;
    end
    chk(rv[HS_BUSY], 1'b0);
  endtask
  task automatic t_status();
    send(CMD_STATUS_READ, 1'b0);
    rreg(HREG_STAT);
    chk(rv[HS_REFUSED], 1'b1);
    wreg(HREG_STAT, 32'h0000_0030);
    send(CMD_DRIVE_RAIL_INIT, 1'b0);
    send(CMD_SUPPLY_INIT, 1'b0);
    for (int k = 0; k < 4; k++) begin
      rail_ready <= k[0];
      supply_low <= k[1];
      send(CMD_STATUS_READ, 1'b0);
      getb({2'h0, ~k[0], k[1], 2'h0, CHIP});
    end
  endtask
  task automatic t_table();
    logic [7:0] tv;
    crc = CRC_SEED;
    send(CMD_TABLE_WRITE, 1'b0);
    for (int i = 0; i < TABLE_BYTES; i++) begin
      tv = tbyte(i);
      send(tv, 1'b1);
      for (int b = 7; b >= 0; b--)
        crc = (crc[15] ^ tv[b]) ? {crc[14:0], 1'b0} ^ CRC_POLY : {crc[14:0], 1'b0};
    end
    // Program without earlier RAM load must be refused
    send(CMD_WS_PROGRAM, 1'b0);
    rreg(HREG_STAT);
    chk(rv[HS_REFUSED], 1'b1);
    wreg(HREG_STAT, 32'h0000_0030);
    send(CMD_RAM_WRITE_BW, 1'b0);
    send(CMD_WS_PROGRAM, 1'b0);
    idle();
    send(CMD_WS_LOAD, 1'b0);
    idle();
    send(CMD_CRC_CALC, 1'b0);
    repeat (2) @(posedge clk);
    #1 chk(busy_o, 1'b1);
    idle();
    send(CMD_CRC_READ, 1'b0);
    getb(crc[15:8]);
    getb(crc[7:0]);
    // Stray table byte, then load must restore the stored table
    send(CMD_TABLE_WRITE, 1'b0);
    send(8'hFF, 1'b1);
    send(CMD_WS_LOAD, 1'b0);
    idle();
    rreg(HREG_STAT);
    chk(rv[HS_SHORT], 1'b1);
    wreg(HREG_STAT, 32'h0000_0030);
    send(CMD_WS_PROGRAM, 1'b0);
    idle();
    send(CMD_CRC_CALC, 1'b0);
    idle();
    send(CMD_CRC_READ, 1'b0);
    getb(crc[15:8]);
    getb(crc[7:0]);
  endtask
  task automatic t_sel();
    send(CMD_SEL_WRITE, 1'b0);
    for (int i = 0; i < SEL_BYTES; i++)
      send(8'hF0 + 8'(i), 1'b1);
    send(CMD_USER_ID_WRITE, 1'b0);
    for (int i = 0; i < USER_ID_BYTES; i++)
      send(8'hA0 + 8'(i), 1'b1);
    wreg(HREG_CFG, 32'h0000_0000);
    rreg(HREG_CFG);
    chk(rv, 32'h0000_0000);
    send(CMD_SEL_PROGRAM, 1'b0);
    rreg(HREG_STAT);
    chk(rv[HS_REFUSED], 1'b1);
    wreg(HREG_STAT, 32'h0000_0030);
    wreg(HREG_CFG, 32'h0000_0001);
    send(CMD_SEL_PROGRAM, 1'b0);
    idle();
    chk(spare_sel, 1'b1);
    send(CMD_USER_ID_READ, 1'b0);
    for (int i = 0; i < USER_ID_BYTES; i++)
      getb(8'hA0 + 8'(i));
    send(CMD_OPTION_READ, 1'b0);
    getb(8'h80);
    getb(LEVEL);
    for (int i = 1; i < SEL_BYTES; i++)
      getb(8'hF0 + 8'(i));
  endtask
  task automatic results();
    $display("Counts: checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wreg(HREG_CFG, 32'h0000_0001);
    t_status();
    t_table();
    t_sel();
    rreg(5'h1C);
    chk(rv, 32'h0000_0000);
    results();
  end
endmodule
`default_nettype wire
